//--- logic/tmr16_pkg.sv
// package: register map, field positions, reset values and types of the 16-bit timer
//
// Functional notes
// - second register in capture latches counter on primary valid edge: 00 fall, 01 rise, 11 both.
// - second capture/compare register resets to zero; written as one 16-bit word.
// - counter runs only when mode bits nonzero; otherwise held at zero, no interrupts.
// - mode 01 free run, 10 clear on primary edge, 11 clear on first match.
// - output timing bit adds the primary valid edge to the output events.
// - clear-on-first-match mode with first register all ones sets overflow on wrap.
// - one-shot mode accepts software trigger and primary edge; each trigger clears the counter.
// - second register mode bit: 0 compare, 1 capture.
// - first register trigger bit: 0 secondary edge, 1 opposite of primary valid edge.
// - first register mode bit: 0 compare, 1 capture.
// - writing 1 to software trigger fires one-shot; bit self-clears, reads 0.
// - one-shot enable: 0 triggers ignored, 1 software trigger and primary valid edge clear the counter.
// - invert bit makes output toggle on each second-register match, except when a first-register toggle event falls in the same cycle.
// - invert bit makes output toggle on first-register match, and on primary valid edge when timing bit set.
// - level pair: 00 none, 01 force low, 10 force high; both read back 0.
// - output enable 0 drives pin low; 1 passes internal output level.
// - counter increments on count clock rising edge; clears on reset, stop, clears, triggers.
// - in compare use a match raises that register's interrupt request.
// - count clock select: 00 sys/4, 01 sys/16, 10 other timer output, 11 primary edge.
package tmr16_pkg;
  localparam logic [15:0] ADR_FIRST_REG   = 16'hff10;
  localparam logic [15:0] ADR_SECOND_REG  = 16'hff12;
  localparam logic [15:0] ADR_COUNTER     = 16'hff14;
  localparam logic [15:0] ADR_CAPCMP_CTRL = 16'hff16;
  localparam logic [15:0] ADR_MODE_CTRL   = 16'hff18;
  localparam logic [15:0] ADR_OUT_CTRL    = 16'hff1a;
  localparam logic [15:0] ADR_PRESCALE    = 16'hff1c;

  localparam logic [7:0] RST_CAPCMP_CTRL = 8'h04;
  localparam logic [7:0] RST_MODE_CTRL   = 8'h00;
  localparam logic [7:0] RST_OUT_CTRL    = 8'h00;
  localparam logic [7:0] RST_PRESCALE    = 8'h00;
  localparam logic [15:0] RST_CAPCMP     = 16'h0000;

  // mode control fields
  localparam int MODE_OVF   = 0;
  localparam int MODE_TIMING = 1;
  localparam int MODE_LO    = 2;
  localparam int MODE_HI    = 3;
  // capture/compare control fields
  localparam int CC_FIRST_CAP  = 0;
  localparam int CC_FIRST_TRIG = 1;
  localparam int CC_SECOND_CAP = 2;
  // output control fields
  localparam int OC_ENABLE    = 0;
  localparam int OC_INV_FIRST = 1;
  localparam int OC_FORCE_LO  = 2;
  localparam int OC_FORCE_HI  = 3;
  localparam int OC_INV_SECOND = 4;
  localparam int OC_OS_ENABLE = 5;
  localparam int OC_OS_TRIG   = 6;
  // prescale/edge fields
  localparam int PS_CLK_LO  = 0;
  localparam int PS_EDGE0_LO = 4;
  localparam int PS_EDGE1_LO = 6;

  localparam logic [7:0] MASK_CAPCMP_CTRL = 8'h07;
  localparam logic [7:0] MASK_MODE_CTRL   = 8'h0f;
  localparam logic [7:0] MASK_OUT_CTRL    = 8'h33;
  localparam logic [7:0] MASK_PRESCALE    = 8'hf3;

  localparam logic [1:0] MODE_STOP     = 2'h0;
  localparam logic [1:0] MODE_FREE     = 2'h1;
  localparam logic [1:0] MODE_CLR_EDGE = 2'h2;
  localparam logic [1:0] MODE_CLR_CMP  = 2'h3;

  localparam logic [1:0] CLK_DIV4  = 2'h0;
  localparam logic [1:0] CLK_DIV16 = 2'h1;
  localparam logic [1:0] CLK_EXT   = 2'h2;
  localparam logic [1:0] CLK_EDGE  = 2'h3;

  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [3:0] DIV4_LAST  = 4'h3;
  localparam logic [3:0] DIV16_LAST = 4'hf;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

  typedef struct packed {
    logic [15:0] first_reg;
    logic [15:0] second_reg;
    logic [15:0] counter;
    logic [7:0]  capcmp_ctrl;
    logic [7:0]  mode_ctrl;
    logic [7:0]  out_ctrl;
    logic [7:0]  prescale;
    logic [3:0]  div;
    logic [2:0]  pri_sync;
    logic [2:0]  sec_sync;
    logic [2:0]  ext_sync;
    logic        pri_lvl;
    logic        sec_lvl;
    logic        ext_lvl;
    logic        out_lvl;
    logic        pin;
    logic        os_armed;
    logic        first_irq;
    logic        second_irq;
    bus_state_e  bus;
    logic [31:0] rdata;
  } state_s;
endpackage : tmr16_pkg

//--- logic/tmr16.sv
// 16-bit timer/event counter with two capture/compare registers and a wishbone slave
`timescale 1ns/1ps
module tmr16 (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        primary_in_pin_i,
  input  wire logic        secondary_in_pin_i,
  input  wire logic        ext_count_clk_i,
  output logic             timer_out_pin_o,
  output logic             first_match_irq_o,
  output logic             second_match_irq_o
);
  tmr16_pkg::state_s q, d;

  logic [1:0] mode;
  logic [1:0] e0;
  logic [1:0] e1;
  logic       running;
  logic       pri_chg;
  logic       sec_chg;
  logic       pri_rise;
  logic       pri_fall;
  logic       sec_rise;
  logic       sec_fall;
  logic       pri_valid;
  logic       pri_rev;
  logic       sec_valid;
  logic       tick;
  logic       match0;
  logic       match1;
  logic       cap0;
  logic       cap1;
  logic       clr;
  logic       sw_trig;
  logic       os_trig;
  logic       tgl;
  logic       ovf_set;
  logic       wr;
  logic       rd_req;
  logic [7:0] wb8;
  logic [15:0] wb16;

  always_comb begin
    mode    = q.mode_ctrl[tmr16_pkg::MODE_HI:tmr16_pkg::MODE_LO];
    e0      = q.prescale[tmr16_pkg::PS_EDGE0_LO +: 2];
    e1      = q.prescale[tmr16_pkg::PS_EDGE1_LO +: 2];
    running = (mode != tmr16_pkg::MODE_STOP);
    // a change counts once the second and third sync stages agree
    pri_chg  = (q.pri_sync[2] == q.pri_sync[1]) && (q.pri_sync[1] != q.pri_lvl);
    sec_chg  = (q.sec_sync[2] == q.sec_sync[1]) && (q.sec_sync[1] != q.sec_lvl);
    pri_rise = pri_chg && q.pri_sync[1];
    pri_fall = pri_chg && !q.pri_sync[1];
    sec_rise = sec_chg && q.sec_sync[1];
    sec_fall = sec_chg && !q.sec_sync[1];
    case (e0)
      tmr16_pkg::EDGE_FALL: pri_valid = pri_fall;
      tmr16_pkg::EDGE_RISE: pri_valid = pri_rise;
      tmr16_pkg::EDGE_BOTH: pri_valid = pri_chg;
      default:              pri_valid = 1'b0;
    endcase
    // opposite edge of the primary valid edge
    case (e0)
      tmr16_pkg::EDGE_FALL: pri_rev = pri_rise;
      tmr16_pkg::EDGE_RISE: pri_rev = pri_fall;
      default:              pri_rev = 1'b0;
    endcase
    case (e1)
      tmr16_pkg::EDGE_FALL: sec_valid = sec_fall;
      tmr16_pkg::EDGE_RISE: sec_valid = sec_rise;
      tmr16_pkg::EDGE_BOTH: sec_valid = sec_chg;
      default:              sec_valid = 1'b0;
    endcase
    case (q.prescale[tmr16_pkg::PS_CLK_LO +: 2])
      tmr16_pkg::CLK_DIV4:  tick = (q.div[1:0] == tmr16_pkg::DIV4_LAST[1:0]);
      tmr16_pkg::CLK_DIV16: tick = (q.div == tmr16_pkg::DIV16_LAST);
      tmr16_pkg::CLK_EXT:   tick = (q.ext_sync[2] == q.ext_sync[1]) && q.ext_sync[1]
                                   && !q.ext_lvl;
      default:              tick = pri_valid;
    endcase
    match0 = running && !q.capcmp_ctrl[tmr16_pkg::CC_FIRST_CAP] && (q.counter == q.first_reg);
    match1 = running && !q.capcmp_ctrl[tmr16_pkg::CC_SECOND_CAP] && (q.counter == q.second_reg);
    cap1   = running && q.capcmp_ctrl[tmr16_pkg::CC_SECOND_CAP] && pri_valid;
    cap0   = running && q.capcmp_ctrl[tmr16_pkg::CC_FIRST_CAP]
             && (q.capcmp_ctrl[tmr16_pkg::CC_FIRST_TRIG] ? pri_rev : sec_valid);
    wr     = wb_cyc_i && wb_stb_i && wb_we_i && (q.bus == tmr16_pkg::BUS_IDLE);
    rd_req = wb_cyc_i && wb_stb_i && (q.bus == tmr16_pkg::BUS_IDLE);
    wb8    = wb_dat_i[7:0];
    wb16   = wb_dat_i[15:0];
    sw_trig = wr && (wb_adr_i == tmr16_pkg::ADR_OUT_CTRL) && wb_sel_i[0]
              && wb8[tmr16_pkg::OC_OS_TRIG];
    os_trig = running && q.out_ctrl[tmr16_pkg::OC_OS_ENABLE]
              && (sw_trig || pri_valid);
    clr = (mode == tmr16_pkg::MODE_CLR_EDGE && pri_valid)
          || (mode == tmr16_pkg::MODE_CLR_CMP && match0 && tick)
          || os_trig;
    // one toggle per match: the counter holds between ticks, so qualify with the tick
    tgl = (q.out_ctrl[tmr16_pkg::OC_INV_SECOND] && match1 && tick)
          ^ (q.out_ctrl[tmr16_pkg::OC_INV_FIRST]
             && ((match0 && tick) || (q.mode_ctrl[tmr16_pkg::MODE_TIMING] && pri_valid)));
    // wrap from all ones happens through the clear, so detect it here
    ovf_set = running && tick && mode == tmr16_pkg::MODE_CLR_CMP
              && q.counter == 16'hffff && q.first_reg == 16'hffff;
  end

  always_comb begin
    d = q;
    d.pri_sync   = {q.pri_sync[1:0], primary_in_pin_i};
    d.sec_sync   = {q.sec_sync[1:0], secondary_in_pin_i};
    d.ext_sync   = {q.ext_sync[1:0], ext_count_clk_i};
    if (pri_chg) d.pri_lvl = q.pri_sync[1];
    if (sec_chg) d.sec_lvl = q.sec_sync[1];
    if (q.ext_sync[2] == q.ext_sync[1]) d.ext_lvl = q.ext_sync[1];
    d.div        = q.div + 4'h1;
    d.first_irq  = match0 || cap0;
    d.second_irq = match1 || cap1;
    if (!running) begin
      d.counter = 16'h0000;
    end else if (clr) begin
      d.counter = 16'h0000;
    end else if (tick) begin
      d.counter = q.counter + 16'h0001;
    end
    if (cap0) d.first_reg = q.counter;
    if (cap1) d.second_reg = q.counter;
    if (running && tgl) d.out_lvl = !q.out_lvl;
    // register writes
    if (wr && wb_sel_i[0]) begin
      case (wb_adr_i)
        tmr16_pkg::ADR_CAPCMP_CTRL: d.capcmp_ctrl = wb8 & tmr16_pkg::MASK_CAPCMP_CTRL;
        tmr16_pkg::ADR_MODE_CTRL: begin
          d.mode_ctrl = wb8 & tmr16_pkg::MASK_MODE_CTRL;
        end
        tmr16_pkg::ADR_OUT_CTRL: begin
          d.out_ctrl = wb8 & tmr16_pkg::MASK_OUT_CTRL;
          if (wb8[tmr16_pkg::OC_FORCE_LO] && !wb8[tmr16_pkg::OC_FORCE_HI]) d.out_lvl = 1'b0;
          if (wb8[tmr16_pkg::OC_FORCE_HI] && !wb8[tmr16_pkg::OC_FORCE_LO]) d.out_lvl = 1'b1;
        end
        tmr16_pkg::ADR_PRESCALE: d.prescale = wb8 & tmr16_pkg::MASK_PRESCALE;
        default: ;
      endcase
    end
    // overflow set by hardware wins over a software clear
    if (ovf_set) d.mode_ctrl[tmr16_pkg::MODE_OVF] = 1'b1;
    if (wr && wb_sel_i[1:0] == 2'b11) begin
      if (wb_adr_i == tmr16_pkg::ADR_FIRST_REG) d.first_reg = wb16;
      if (wb_adr_i == tmr16_pkg::ADR_SECOND_REG) d.second_reg = wb16;
    end
    d.pin = q.out_ctrl[tmr16_pkg::OC_ENABLE] ? d.out_lvl : 1'b0;
    // bus answer, one cycle after the strobe, dropped the next cycle
    case (q.bus)
      tmr16_pkg::BUS_IDLE: begin
        if (rd_req) d.bus = tmr16_pkg::BUS_ACK;
        d.rdata = 32'h0000_0000;
        case (wb_adr_i)
          tmr16_pkg::ADR_FIRST_REG:   d.rdata = {16'h0000, q.first_reg};
          tmr16_pkg::ADR_SECOND_REG:  d.rdata = {16'h0000, q.second_reg};
          tmr16_pkg::ADR_COUNTER:     d.rdata = {16'h0000, q.counter};
          tmr16_pkg::ADR_CAPCMP_CTRL: d.rdata = {24'h000000, q.capcmp_ctrl};
          tmr16_pkg::ADR_MODE_CTRL:   d.rdata = {24'h000000, q.mode_ctrl};
          tmr16_pkg::ADR_OUT_CTRL:    d.rdata = {24'h000000, q.out_ctrl};
          tmr16_pkg::ADR_PRESCALE:    d.rdata = {24'h000000, q.prescale};
          default:                    d.rdata = 32'h0000_0000;
        endcase
      end
      tmr16_pkg::BUS_ACK: d.bus = tmr16_pkg::BUS_IDLE;
      default: d.bus = tmr16_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q             <= '0;
      q.first_reg   <= tmr16_pkg::RST_CAPCMP;
      q.second_reg  <= tmr16_pkg::RST_CAPCMP;
      q.capcmp_ctrl <= tmr16_pkg::RST_CAPCMP_CTRL;
      q.mode_ctrl   <= tmr16_pkg::RST_MODE_CTRL;
      q.out_ctrl    <= tmr16_pkg::RST_OUT_CTRL;
      q.prescale    <= tmr16_pkg::RST_PRESCALE;
      q.bus         <= tmr16_pkg::BUS_IDLE;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o           = q.rdata;
  assign wb_ack_o           = (q.bus == tmr16_pkg::BUS_ACK);
  assign timer_out_pin_o    = q.pin;
  assign first_match_irq_o  = q.first_irq;
  assign second_match_irq_o = q.second_irq;
endmodule : tmr16

//--- test/tmr16_checker.sv
// checker: port-level properties of the 16-bit timer
`timescale 1ns/1ps
module tmr16_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        timer_out_pin_o,
  input wire logic        first_match_irq_o,
  input wire logic        second_match_irq_o
);
  logic       take;
  logic       rd;
  logic [1:0] mode_q;
  logic       oe_q;
  logic [1:0] stop_q;
  assign take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign rd = wb_ack_o && !wb_we_i;
  // shadow of the run mode and output enable, and cycles spent stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= 2'h0;
      oe_q   <= 1'b0;
      stop_q <= 2'h0;
    end else begin
      if (take && wb_adr_i == tmr16_pkg::ADR_MODE_CTRL) mode_q <= wb_dat_i[3:2];
      if (take && wb_adr_i == tmr16_pkg::ADR_OUT_CTRL) oe_q <= wb_dat_i[0];
      stop_q <= (mode_q != 2'h0) ? 2'h0 : ((stop_q == 2'h3) ? 2'h3 : stop_q + 2'h1);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_latency: assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !timer_out_pin_o
    && !first_match_irq_o && !second_match_irq_o) else $error("outputs active after reset");
  chk_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  chk_self_clear: assert property (rd && wb_adr_i == tmr16_pkg::ADR_OUT_CTRL |->
    (wb_dat_o[7:0] & ~tmr16_pkg::MASK_OUT_CTRL) == 8'h00) else $error("trigger bits read 1");
  chk_stop_quiet: assert property (stop_q == 2'h3 |-> !first_match_irq_o && !second_match_irq_o)
    else $error("interrupt while stopped");
  chk_stop_zero: assert property (stop_q == 2'h3 && rd && wb_adr_i == tmr16_pkg::ADR_COUNTER
    |-> wb_dat_o == 32'h0) else $error("counter not zero while stopped");
  chk_pin_off: assert property (!oe_q && !$past(oe_q) |-> !timer_out_pin_o)
    else $error("pin high while output disabled");
  cov_first_irq: cover property (first_match_irq_o);
  cov_second_irq: cover property (second_match_irq_o);
  cov_pin_high: cover property (timer_out_pin_o);
endmodule : tmr16_checker

bind tmr16 tmr16_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .timer_out_pin_o(timer_out_pin_o), .first_match_irq_o(first_match_irq_o),
  .second_match_irq_o(second_match_irq_o));

//--- test/tmr16_pins.sv
// pin model: external pulse sources feeding the timer inputs
`timescale 1ns/1ps
module tmr16_pins (
  input  wire logic clk_i,
  input  wire logic pri_i,
  input  wire logic ext_run_i,
  output logic      primary_in_pin_o,
  output logic      secondary_in_pin_o,
  output logic      ext_count_clk_o
);
  logic [1:0] div_q = 2'h0;
  initial primary_in_pin_o = 1'b0;
  initial ext_count_clk_o = 1'b0;
  // secondary source idles high; primary only moves when commanded
  assign secondary_in_pin_o = 1'b1;
  always @(posedge clk_i) begin
    primary_in_pin_o <= pri_i;
    div_q <= div_q + 2'h1;
    // outside a run the count clock stands low
    ext_count_clk_o <= ext_run_i && div_q[1];
  end
endmodule : tmr16_pins

//--- test/tb_timer16_capture_compare_ctrl.sv
// testbench: register, pin, compare and capture checks of the 16-bit timer
`timescale 1ns/1ps
module tb_timer16_capture_compare_ctrl;
  localparam logic [7:0] FV [4] = '{8'h09, 8'h08, 8'h09, 8'h05};
  localparam logic [3:0] PE = 4'b0101;
  localparam int LO [4] = '{20, 4, 20, 0};
  localparam int HI [4] = '{28, 8, 28, 0};
  localparam logic [7:0] PS [4] = '{8'h00, 8'h10, 8'h30, 8'h20};
  localparam int CAPS [4] = '{1, 1, 2, 0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] adr = 16'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic pri = 1'b0;
  logic ext_run = 1'b0;
  logic [31:0] rdat, q;
  logic ack, pin, irq1, irq2, pri_pin, sec_pin, ext_pin, f_q, s_q, p_q;
  int mismatches = 0;
  int n_checks = 0;
  int n1, n2, nt;
  tmr16 dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .primary_in_pin_i(pri_pin), .secondary_in_pin_i(sec_pin), .ext_count_clk_i(ext_pin),
    .timer_out_pin_o(pin), .first_match_irq_o(irq1), .second_match_irq_o(irq2));
  tmr16_pins pins_u (.clk_i(clk_i), .pri_i(pri), .ext_run_i(ext_run),
    .primary_in_pin_o(pri_pin), .secondary_in_pin_o(sec_pin), .ext_count_clk_o(ext_pin));
  always #5 clk_i = ~clk_i;
  // counts interrupt pulses and output pin changes
  always @(posedge clk_i) begin
    if (irq1 === 1'b1 && f_q !== 1'b1) n1++;
    if (irq2 === 1'b1 && s_q !== 1'b1) n2++;
    if (pin !== p_q) nt++;
    f_q <= irq1;
    s_q <= irq2;
    p_q <= pin;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wb(input logic [15:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= a;
    we <= w;
    dat <= d;
    sel <= s;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (ack !== 1'b1) check(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0, 4'hf);
    check(q, e);
  endtask : rchk
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++)
      rchk(16'hff10 + 16'(2 * i), (i == 3) ? {24'h0, tmr16_pkg::RST_CAPCMP_CTRL} : 32'h0);
    wb(tmr16_pkg::ADR_OUT_CTRL, 1'b1, 32'h65, 4'hf);
    rchk(tmr16_pkg::ADR_OUT_CTRL, 32'h21);
    for (int i = 0; i < 4; i++) begin
      wb(tmr16_pkg::ADR_OUT_CTRL, 1'b1, {24'h0, FV[i]}, 4'hf);
      repeat (2) @(posedge clk_i);
      check({31'h0, pin}, {31'h0, PE[i]});
    end
    wb(tmr16_pkg::ADR_SECOND_REG, 1'b1, 32'h1234, 4'hf);
    wb(tmr16_pkg::ADR_SECOND_REG, 1'b1, 32'habcd, 4'h1);
    rchk(tmr16_pkg::ADR_SECOND_REG, 32'h1234);
    for (int i = 0; i < 4; i++) begin
      ext_run <= (i == 2);
      wb(tmr16_pkg::ADR_MODE_CTRL, 1'b1, 32'h0, 4'hf);
      wb(tmr16_pkg::ADR_PRESCALE, 1'b1, 32'(i), 4'hf);
      wb(tmr16_pkg::ADR_MODE_CTRL, 1'b1, 32'h4, 4'hf);
      repeat (100) @(posedge clk_i);
      wb(tmr16_pkg::ADR_COUNTER, 1'b0, 32'h0, 4'hf);
      check({31'h0, q >= LO[i] && q <= HI[i]}, 32'h1);
    end
    wb(tmr16_pkg::ADR_MODE_CTRL, 1'b1, 32'h0, 4'hf);
    wb(tmr16_pkg::ADR_PRESCALE, 1'b1, 32'h0, 4'hf);
    wb(tmr16_pkg::ADR_CAPCMP_CTRL, 1'b1, 32'h0, 4'hf);
    wb(tmr16_pkg::ADR_FIRST_REG, 1'b1, 32'h5, 4'hf);
    wb(tmr16_pkg::ADR_SECOND_REG, 1'b1, 32'h3, 4'hf);
    wb(tmr16_pkg::ADR_OUT_CTRL, 1'b1, 32'h13, 4'hf);
    wb(tmr16_pkg::ADR_MODE_CTRL, 1'b1, 32'hc, 4'hf);
    n1 = 0;
    n2 = 0;
    nt = 0;
    // six ticks of four clocks per period: ten periods
    repeat (240) @(posedge clk_i);
    check({31'h0, n1 >= 9 && n1 <= 11}, 32'h1);
    check({31'h0, n2 >= 9 && n2 <= 11}, 32'h1);
    check({31'h0, nt >= 18 && nt <= 22}, 32'h1);
    wb(tmr16_pkg::ADR_COUNTER, 1'b0, 32'h0, 4'hf);
    check({31'h0, q <= 32'h5}, 32'h1);
    wb(tmr16_pkg::ADR_MODE_CTRL, 1'b1, 32'h0, 4'hf);
    repeat (3) @(posedge clk_i);
    n1 = 0;
    n2 = 0;
    repeat (20) @(posedge clk_i);
    rchk(tmr16_pkg::ADR_COUNTER, 32'h0);
    check(32'(n1 + n2), 32'h0);
    wb(tmr16_pkg::ADR_FIRST_REG, 1'b1, 32'hffff, 4'hf);
    wb(tmr16_pkg::ADR_CAPCMP_CTRL, 1'b1, 32'h4, 4'hf);
    for (int i = 0; i < 4; i++) begin
      wb(tmr16_pkg::ADR_MODE_CTRL, 1'b1, 32'h0, 4'hf);
      wb(tmr16_pkg::ADR_PRESCALE, 1'b1, {24'h0, PS[i]}, 4'hf);
      wb(tmr16_pkg::ADR_MODE_CTRL, 1'b1, 32'h4, 4'hf);
      n2 = 0;
      repeat (10) @(posedge clk_i);
      pri <= 1'b1;
      repeat (10) @(posedge clk_i);
      pri <= 1'b0;
      repeat (10) @(posedge clk_i);
      check(32'(n2), 32'(CAPS[i]));
    end
    // one-shot: software trigger restarts a running counter
    wb(tmr16_pkg::ADR_MODE_CTRL, 1'b1, 32'h0, 4'hf);
    wb(tmr16_pkg::ADR_OUT_CTRL, 1'b1, 32'h21, 4'hf);
    wb(tmr16_pkg::ADR_MODE_CTRL, 1'b1, 32'h4, 4'hf);
    repeat (100) @(posedge clk_i);
    wb(tmr16_pkg::ADR_OUT_CTRL, 1'b1, 32'h61, 4'hf);
    wb(tmr16_pkg::ADR_COUNTER, 1'b0, 32'h0, 4'hf);
    check({31'h0, q <= 32'h2}, 32'h1);
    rchk(tmr16_pkg::ADR_OUT_CTRL, 32'h21);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
endmodule : tb_timer16_capture_compare_ctrl
